/* File: core/bud_pkg.sv */
package bud_pkg;

	localparam int ADDR_WIDTH = 7;
	localparam int DATA_WIDTH = 8;

	// operation codes presented by the sequencer
	typedef enum logic [2:0] {
		complement_file_op = 3'h0,
		clear_file_op = 3'h1,
		decrement_file_op = 3'h2,
		clear_accumulator_op = 3'h3,
		decrement_skip_zero_op = 3'h4,
		increment_skip_zero_op = 3'h5,
		no_operation = 3'h6
	} bud_op_type;

	localparam logic DEST_ACCUM = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	localparam logic [DATA_WIDTH-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_WIDTH-1:0] ONE_BYTE = 8'h01;
	localparam logic [DATA_WIDTH-1:0] RESET_ACCUM = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] RESET_ADDR = 7'h00;
	localparam logic RESET_ZERO_FLAG = 1'b0;

endpackage : bud_pkg

/* File: core/bud_file_mem.sv */
module bud_file_mem
	import bud_pkg::*;
#(
	parameter int AW = ADDR_WIDTH,
	parameter int DW = DATA_WIDTH
) (
	input wire logic clk_sys,
	input wire logic writeEn,
	input wire logic [AW-1:0] writeAddr,
	input wire logic [DW-1:0] writeData,
	input wire logic [AW-1:0] readAddr,
	output logic [DW-1:0] readData
);

	logic [DW-1:0] store [0:(1<<AW)-1];

	// write-first bypass: a read of the word being written sees the new value
	wire bypass = writeEn && (writeAddr == readAddr);

	always_ff @(posedge clk_sys) begin
		if (writeEn) begin
			store[writeAddr] <= writeData;
		end
	end

	always_ff @(posedge clk_sys) begin
		readData <= bypass ? writeData : store[readAddr];
	end

endmodule : bud_file_mem

/* File: core/bud_datapath.sv */
module bud_datapath
	import bud_pkg::*;
#(
	parameter int AW = ADDR_WIDTH,
	parameter int DW = DATA_WIDTH
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic opValid,
	input wire bud_op_type opCode,
	input wire logic [AW-1:0] opAddr,
	input wire logic opDest,
	input wire logic loadEn,
	input wire logic [AW-1:0] loadAddr,
	input wire logic [DW-1:0] loadData,
	output logic opReady,
	output logic doneValid,
	output logic skipTaken,
	output logic nopCycle,
	output logic [DW-1:0] resultData,
	output logic resultToFile,
	output logic [DW-1:0] accum,
	output logic zeroFlag
);

	////////////////////////////////////////////////////////////////
	// issue stage

	logic exValid;
	bud_op_type exOp;
	logic [AW-1:0] exAddr;
	logic exDest;
	logic [DW-1:0] fileData;

	wire take = opValid && opReady;
	wire opIsSkip = (opCode == decrement_skip_zero_op) || (opCode == increment_skip_zero_op);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			exValid <= 1'b0;
			exOp <= no_operation;
			exAddr <= RESET_ADDR;
			exDest <= DEST_ACCUM;
		end else begin
			exValid <= take;
			if (take) begin
				exOp <= opCode;
				exAddr <= opAddr;
				exDest <= opDest;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// execute stage

	wire isComp = exOp == complement_file_op;
	wire isClrF = exOp == clear_file_op;
	wire isDec = exOp == decrement_file_op;
	wire isClrW = exOp == clear_accumulator_op;
	wire isDecSkip = exOp == decrement_skip_zero_op;
	wire isIncSkip = exOp == increment_skip_zero_op;
	wire exIsSkip = isDecSkip || isIncSkip;
	wire usesDest = isComp || isDec || exIsSkip;
	// unknown codes behave as a no-operation
	wire exActive = exValid && (usesDest || isClrF || isClrW);

	wire [DW-1:0] compVal = ~fileData;
	wire [DW-1:0] decVal = DW'(fileData - ONE_BYTE);
	wire [DW-1:0] incVal = DW'(fileData + ONE_BYTE);
	wire [DW-1:0] exResult = isComp ? compVal :
		(isDec || isDecSkip) ? decVal :
		isIncSkip ? incVal : ZERO_BYTE;
	wire exZero = exResult == ZERO_BYTE;

	wire exWritesFile = exActive && (isClrF || (usesDest && exDest == DEST_FILE));
	wire exWritesAcc = exActive && (isClrW || (usesDest && exDest == DEST_ACCUM));
	// skip forms leave the status alone
	wire exUpdZ = exActive && !exIsSkip;
	wire exSkip = exValid && exIsSkip && exZero;

	// execution writes win over the side load port
	wire memWe = exWritesFile || loadEn;
	wire [AW-1:0] memWaddr = exWritesFile ? exAddr : loadAddr;
	wire [DW-1:0] memWdata = exWritesFile ? exResult : loadData;

	// a skip op holds issue until its outcome is known; a taken skip adds the nop slot
	wire next_opReady = !(take && opIsSkip) && !exSkip;

	bud_file_mem #(
		.AW(AW),
		.DW(DW)
	) fileMem (
		.clk_sys(clk_sys),
		.writeEn(memWe),
		.writeAddr(memWaddr),
		.writeData(memWdata),
		.readAddr(opAddr),
		.readData(fileData)
	);

	////////////////////////////////////////////////////////////////
	// architectural state and outputs

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			accum <= RESET_ACCUM;
			zeroFlag <= RESET_ZERO_FLAG;
		end else begin
			if (exWritesAcc) begin
				accum <= exResult;
			end
			if (exUpdZ) begin
				zeroFlag <= exZero;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			opReady <= 1'b1;
			doneValid <= 1'b0;
			skipTaken <= 1'b0;
			nopCycle <= 1'b0;
			resultData <= ZERO_BYTE;
			resultToFile <= 1'b0;
		end else begin
			opReady <= next_opReady;
			doneValid <= exValid;
			skipTaken <= exSkip;
			nopCycle <= exSkip;
			resultToFile <= exWritesFile;
			if (exValid) begin
				resultData <= exResult;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	property p_dest_accum;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && usesDest && exDest == DEST_ACCUM |=> accum == resultData && !resultToFile;
	endproperty
	a_dest_accum: assert property (p_dest_accum) else $error("accumulator destination not honoured");

	property p_dest_file;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && usesDest && exDest == DEST_FILE |=> resultToFile && accum == $past(accum);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("file destination not honoured");

	property p_file_readback;
		@(posedge clk_sys) disable iff (!rstn)
		exWritesFile && !take ##1 take && opAddr == $past(exAddr) |=> fileData == $past(resultData);
	endproperty
	a_file_readback: assert property (p_file_readback) else $error("file write lost");

	property p_complement;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isComp |=> resultData == ~$past(fileData) && zeroFlag == (resultData == ZERO_BYTE);
	endproperty
	a_complement: assert property (p_complement) else $error("complement result wrong");

	property p_clear_file;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isClrF |=> resultData == ZERO_BYTE && zeroFlag && resultToFile;
	endproperty
	a_clear_file: assert property (p_clear_file) else $error("clear file wrong");

	property p_decrement;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isDec |=> resultData == DW'($past(fileData) - ONE_BYTE) && !skipTaken;
	endproperty
	a_decrement: assert property (p_decrement) else $error("decrement result wrong");

	property p_clear_accum;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isClrW |=> accum == ZERO_BYTE && zeroFlag && !resultToFile;
	endproperty
	a_clear_accum: assert property (p_clear_accum) else $error("clear accumulator wrong");

	property p_dec_skip;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isDecSkip |=> zeroFlag == $past(zeroFlag) && skipTaken == (resultData == ZERO_BYTE)
			&& resultData == DW'($past(fileData) - ONE_BYTE);
	endproperty
	a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

	property p_inc_skip;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isIncSkip |=> zeroFlag == $past(zeroFlag) && skipTaken == (resultData == ZERO_BYTE);
	endproperty
	a_inc_skip: assert property (p_inc_skip) else $error("increment skip flags or skip wrong");

	property p_inc_wrap;
		@(posedge clk_sys) disable iff (!rstn)
		exValid && isIncSkip && fileData == ~ZERO_BYTE |=> resultData == ZERO_BYTE && skipTaken;
	endproperty
	a_inc_wrap: assert property (p_inc_wrap) else $error("increment did not wrap");

	property p_zero_flag;
		@(posedge clk_sys) disable iff (!rstn)
		exUpdZ |=> zeroFlag == (resultData == ZERO_BYTE);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

	property p_single_cycle;
		@(posedge clk_sys) disable iff (!rstn)
		take && !opIsSkip |=> exValid && !exSkip ##1 doneValid && !skipTaken && (opReady || $past(take));
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("plain op not single cycle");

	property p_skip_slot;
		@(posedge clk_sys) disable iff (!rstn)
		exSkip |=> nopCycle && !opReady ##1 opReady && !nopCycle;
	endproperty
	a_skip_slot: assert property (p_skip_slot) else $error("skip nop slot wrong");

endmodule : bud_datapath

/* File: bench/bud_datapath_tb_top.sv */
module bud_datapath_tb_top import bud_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic opValid = 1'b0;
	logic opDest = 1'b0;
	logic loadEn = 1'b0;
	bud_op_type opCode = no_operation;
	logic [6:0] opAddr = 7'h00;
	logic [6:0] loadAddr = 7'h00;
	logic [7:0] loadData = 8'h00;
	logic opReady, doneValid, skipTaken, nopCycle, resultToFile, zeroFlag;
	logic [7:0] resultData, accum;
	// bench copy of the file registers, accumulator and zero flag
	logic [7:0] mem [128];
	logic [7:0] expAcc = 8'h00;
	logic expZ = 1'b0;
	int errorCnt = 0;
	int nTests = 0;
	int cycles = 0;

	initial forever #2.5 clk_sys = ~clk_sys;

	bud_datapath uut (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opCode(opCode), .opAddr(opAddr),
		.opDest(opDest), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .opReady(opReady),
		.doneValid(doneValid), .skipTaken(skipTaken), .nopCycle(nopCycle), .resultData(resultData),
		.resultToFile(resultToFile), .accum(accum), .zeroFlag(zeroFlag));

	////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// whole run is well under 1000 cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errorCnt++;
			summarize();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic load(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		loadEn <= 1'b1;
		loadAddr <= a;
		loadData <= d;
		@(posedge clk_sys);
		loadEn <= 1'b0;
		mem[a] = d;
	endtask : load

	// one op: predict, offer until taken, judge at the falling edge after the answer edge
	task automatic run(input bud_op_type op, input logic [6:0] a, input logic d);
		logic [7:0] r;
		logic wf, sk, isSkip;
		int n;
		isSkip = op inside {decrement_skip_zero_op, increment_skip_zero_op};
		case (op)
			complement_file_op: r = ~mem[a];
			decrement_file_op, decrement_skip_zero_op: r = mem[a] - 8'h01;
			increment_skip_zero_op: r = mem[a] + 8'h01;
			default: r = 8'h00;
		endcase
		wf = (op == clear_file_op) || (d == DEST_FILE && !(op inside {clear_accumulator_op, no_operation}));
		sk = isSkip && r == 8'h00;
		if (!isSkip && op != no_operation)
			expZ = (r == 8'h00);
		if (wf)
			mem[a] = r;
		else if (op != no_operation)
			expAcc = r;
		@(posedge clk_sys);
		opValid <= 1'b1;
		opCode <= op;
		opAddr <= a;
		opDest <= d;
		n = 0;
		// ready is looked at mid-cycle, where it is settled, not at the edge that moves it
		@(negedge clk_sys);
		while (opReady !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		chk(opReady, 8'h01);
		@(posedge clk_sys);
		opValid <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(doneValid, 8'h01);
		chk(resultData, r);
		chk(resultToFile, wf);
		chk(accum, expAcc);
		chk(zeroFlag, expZ);
		chk(skipTaken, sk);
		chk(nopCycle, sk);
		chk(opReady, !sk);
	endtask : run

	////////////////////////////////////////////////////////////////
	task automatic t_compl;
		load(7'h7f, 8'hff);
		run(complement_file_op, 7'h7f, DEST_FILE);
		run(complement_file_op, 7'h7f, DEST_ACCUM);
		load(7'h00, 8'h5a);
		run(complement_file_op, 7'h00, DEST_ACCUM);
		$display("test complement done");
	endtask : t_compl

	task automatic t_clear;
		run(clear_file_op, 7'h00, DEST_ACCUM);
		run(complement_file_op, 7'h00, DEST_ACCUM);
		run(no_operation, 7'h00, DEST_FILE);
		run(clear_accumulator_op, 7'h33, DEST_FILE);
		$display("test clear done");
	endtask : t_clear

	task automatic t_dec;
		load(7'h10, 8'h01);
		run(decrement_file_op, 7'h10, DEST_FILE);
		run(decrement_file_op, 7'h10, DEST_ACCUM);
		run(decrement_file_op, 7'h10, DEST_FILE);
		run(complement_file_op, 7'h10, DEST_ACCUM);
		$display("test decrement done");
	endtask : t_dec

	// zero flag is left set before the skips so a stray update shows
	task automatic t_skip;
		load(7'h20, 8'h02);
		run(decrement_skip_zero_op, 7'h20, DEST_FILE);
		run(decrement_skip_zero_op, 7'h20, DEST_FILE);
		run(decrement_skip_zero_op, 7'h20, DEST_ACCUM);
		load(7'h21, 8'hfe);
		run(increment_skip_zero_op, 7'h21, DEST_ACCUM);
		run(increment_skip_zero_op, 7'h21, DEST_FILE);
		run(increment_skip_zero_op, 7'h21, DEST_ACCUM);
		run(increment_skip_zero_op, 7'h21, DEST_FILE);
		$display("test skip done");
	endtask : t_skip

	// one address back to back: the second read rides the bypass, the third follows a gap
	task automatic t_b2b;
		load(7'h40, 8'h04);
		@(posedge clk_sys);
		opValid <= 1'b1;
		opCode <= decrement_file_op;
		opAddr <= 7'h40;
		opDest <= DEST_FILE;
		@(posedge clk_sys);
		@(posedge clk_sys);
		opValid <= 1'b0;
		@(negedge clk_sys);
		chk(doneValid, 8'h01);
		chk(resultData, 8'h03);
		chk(opReady, 8'h01);
		@(posedge clk_sys);
		opValid <= 1'b1;
		opDest <= DEST_ACCUM;
		@(negedge clk_sys);
		chk(doneValid, 8'h01);
		chk(resultData, 8'h02);
		@(posedge clk_sys);
		opValid <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(accum, 8'h01);
		chk(zeroFlag, 8'h00);
		mem[7'h40] = 8'h02;
		expAcc = 8'h01;
		expZ = 1'b0;
		$display("test back to back done");
	endtask : t_b2b

	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		t_compl();
		t_clear();
		t_dec();
		t_skip();
		t_b2b();
		summarize();
	end

endmodule : bud_datapath_tb_top
